// [status_lamp_driver.sv]
`timescale 1ns/1ps
module status_lamp_driver import lamp_pkg::*; #(
   parameter int FLASH_HALF_CYCLES = FAST_HALF_CYCLES
) (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Register bus
   input wire apb_req_t apbReq,
   output apb_rsp_t apbRsp,
   // Unit condition and channel inputs
   input wire unit_flags_t unitFlags,
   input wire chan_in_t chanIn [NUM_CHANNELS],
   // Lamps
   output logic lampGreen,
   output logic lampRed,
   output logic [NUM_CHANNELS-1:0] outLamp
);

   // ==========================================================
   // Per-channel lamp decode
   function automatic logic chanLit(input logic mode, input chan_in_t ch);
      if (mode == MODE_LINEAR) begin
         return ch.mv > 0; // see RULE7
      end
      return ch.outOn; // see RULE6
   endfunction

   logic fastPhase;
   logic slowPhase;
   logic [NUM_CHANNELS-1:0] chanMode;
   logic [NUM_CHANNELS-1:0] next_chanMode;
   logic [31:0] rdData;
   logic [31:0] next_rdData;
   logic rdErr;
   logic next_rdErr;
   lamp_state_t unitState;
   lamp_state_t next_unitState;
   logic next_lampGreen;
   logic next_lampRed;
   logic [NUM_CHANNELS-1:0] next_outLamp;
   logic setup;
   logic access;
   logic [31:0] statusWord;

   // ==========================================================
   // Flash source
   flash_divider #(
      .HALF_CYCLES(FLASH_HALF_CYCLES)
   ) u_div (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .fastPhase(fastPhase),
      .slowPhase(slowPhase)
   );

   // ==========================================================
   // APB slave
   // Answers in the first access cycle; a frozen block holds the bus off
   assign setup = apbReq.psel & ~apbReq.penable;
   assign access = apbReq.psel & apbReq.penable;
   assign apbRsp.pready = ce;
   assign apbRsp.prdata = rdData;
   assign apbRsp.pslverr = rdErr & access;

   always_comb begin
      statusWord = '0;
      statusWord[STATUS_STATE_LSB +: $bits(lamp_state_t)] = unitState;
      statusWord[STATUS_GREEN_BIT] = lampGreen;
      statusWord[STATUS_RED_BIT] = lampRed;
      statusWord[STATUS_LAMPS_LSB +: NUM_CHANNELS] = outLamp;
   end

   // Decode in the setup cycle so read data and error come from flops
   always_comb begin
      next_chanMode = chanMode;
      next_rdData = rdData;
      next_rdErr = rdErr;
      if (ce && setup) begin
         next_rdData = '0;
         next_rdErr = 1'b0;
         case (apbReq.paddr)
            ADDR_STATUS: begin
               next_rdData = statusWord;
            end
            ADDR_MODE: begin
               next_rdData[NUM_CHANNELS-1:0] = chanMode;
            end
            default: begin
               next_rdErr = 1'b1;
            end
         endcase
      end
      // Status is read-only; a write to it is simply dropped
      if (ce && access && apbReq.pwrite && apbReq.paddr == ADDR_MODE) begin
         next_chanMode = apbReq.pwdata[NUM_CHANNELS-1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chanMode <= MODE_RESET;
         rdData <= '0;
         rdErr <= 1'b0;
      end else begin
         chanMode <= next_chanMode;
         rdData <= next_rdData;
         rdErr <= next_rdErr;
      end
   end

   // ==========================================================
   // Unit status lamp
   // Order matters: no power first, then red faults ahead of any green case
   always_comb begin
      next_unitState = unitState;
      if (ce) begin
         if (!unitFlags.powerOk) begin
            next_unitState = ST_DARK; // see RULE5
         end else if (unitFlags.fatalErr) begin
            next_unitState = ST_RED_ON; // see RULE3 see RULE9
         end else if (unitFlags.busErr) begin
            next_unitState = ST_RED_FLASH; // see RULE4 see RULE9
         end else if (unitFlags.restartHalt) begin
            next_unitState = ST_DARK; // see RULE5
         end else if (unitFlags.initializing || unitFlags.restarting
                      || unitFlags.downloading) begin
            next_unitState = ST_GREEN_FLASH; // see RULE2
         end else if (unitFlags.ioReady || unitFlags.ioCheck) begin
            next_unitState = ST_GREEN_ON; // see RULE1
         end else begin
            next_unitState = ST_DARK; // see RULE5
         end
      end
   end

   // Colour from the new state, so lamp and state change together
   always_comb begin
      next_lampGreen = lampGreen;
      next_lampRed = lampRed;
      next_outLamp = outLamp;
      if (ce) begin
         case (next_unitState)
            ST_GREEN_ON: begin
               next_lampGreen = 1'b1;
               next_lampRed = 1'b0;
            end
            ST_GREEN_FLASH: begin
               next_lampGreen = slowPhase; // see RULE2
               next_lampRed = 1'b0;
            end
            ST_RED_ON: begin
               next_lampGreen = 1'b0;
               next_lampRed = 1'b1;
            end
            ST_RED_FLASH: begin
               next_lampGreen = 1'b0;
               next_lampRed = fastPhase; // see RULE4
            end
            default: begin
               next_lampGreen = 1'b0;
               next_lampRed = 1'b0;
            end
         endcase
         for (int i = 0; i < NUM_CHANNELS; i++) begin
            next_outLamp[i] = chanLit(chanMode[i], chanIn[i]); // see RULE8
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         unitState <= ST_DARK;
         lampGreen <= 1'b0;
         lampRed <= 1'b0;
         outLamp <= '0;
      end else begin
         unitState <= next_unitState;
         lampGreen <= next_lampGreen;
         lampRed <= next_lampRed;
         outLamp <= next_outLamp;
      end
   end

   // ==========================================================
   // Checks
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Sampled reset keeps the edge that releases reset, where the flops still clear, out of it
   logic live;
   assign live = rst_n & ce;

   sequence s_powered_clean;
      live && unitFlags.powerOk && !unitFlags.fatalErr && !unitFlags.busErr
         && !unitFlags.restartHalt;
   endsequence

   sequence s_busy;
      unitFlags.initializing || unitFlags.restarting || unitFlags.downloading;
   endsequence

   sequence s_idle_ready;
      !(unitFlags.initializing || unitFlags.restarting || unitFlags.downloading)
         && (unitFlags.ioReady || unitFlags.ioCheck);
   endsequence

   property p_green_steady;
      s_powered_clean ##0 s_idle_ready |=> lampGreen && !lampRed;
   endproperty
   a_green_steady: assert property (p_green_steady) // see RULE1
      else $error("green not steady in normal operation");

   property p_green_flash;
      s_powered_clean ##0 s_busy |=> !lampRed && lampGreen == $past(slowPhase);
   endproperty
   a_green_flash: assert property (p_green_flash) // see RULE2
      else $error("green does not follow slow flash");

   property p_red_steady;
      live && unitFlags.powerOk && unitFlags.fatalErr |=> lampRed && !lampGreen;
   endproperty
   a_red_steady: assert property (p_red_steady) // see RULE3
      else $error("red not steady on fatal error");

   property p_red_flash;
      live && unitFlags.powerOk && !unitFlags.fatalErr && unitFlags.busErr
         |=> !lampGreen && lampRed == $past(fastPhase) && unitState == ST_RED_FLASH;
   endproperty
   a_red_flash: assert property (p_red_flash) // see RULE4
      else $error("red does not follow fast flash on bus error");

   property p_dark;
      live && (!unitFlags.powerOk || (!unitFlags.fatalErr && !unitFlags.busErr
         && (unitFlags.restartHalt || (!unitFlags.initializing && !unitFlags.restarting
         && !unitFlags.downloading && !unitFlags.ioReady && !unitFlags.ioCheck))))
         |=> !lampGreen && !lampRed;
   endproperty
   a_dark: assert property (p_dark) // see RULE5
      else $error("status lamp lit while it should be dark");

   property p_red_beats_green;
      live && unitFlags.powerOk && (unitFlags.fatalErr || unitFlags.busErr) |=> !lampGreen;
   endproperty
   a_red_beats_green: assert property (p_red_beats_green) // see RULE9
      else $error("green shown during a red condition");

   property p_frozen;
      !ce |=> $stable(lampGreen) && $stable(lampRed) && $stable(outLamp);
   endproperty
   a_frozen: assert property (p_frozen)
      else $error("lamps moved while clock enable low");

   for (genvar g = 0; g < NUM_CHANNELS; g++) begin : g_chk
      property p_pulse_lamp;
         live && chanMode[g] == MODE_PULSE |=> outLamp[g] == $past(chanIn[g].outOn);
      endproperty
      a_pulse_lamp: assert property (p_pulse_lamp) // see RULE6
         else $error("pulse channel lamp differs from its output");

      property p_linear_lamp;
         live && chanMode[g] == MODE_LINEAR |=> outLamp[g] == ($past(chanIn[g].mv) > 0);
      endproperty
      a_linear_lamp: assert property (p_linear_lamp) // see RULE7
         else $error("linear channel lamp differs from value sign");
   end

endmodule

// [lamp_pkg.sv]
// Notes on behaviour
// RULE1: Steady green while running normally, ready for refresh or checking inputs/outputs.
// RULE2: Green flashes with a 2 s period while initializing, restarting or downloading.
// RULE3: Steady red on a fatal error such as hardware failure or watchdog timeout.
// RULE4: Red flashes with a 1 s period on a communication or backplane bus error.
// RULE5: Status lamp dark with no power, during restart, or waiting for initialization.
// RULE6: Pulsed voltage channel lamp lit exactly while its control output is on.
// RULE7: Linear current channel lamp lit only while its manipulated variable exceeds 0%.
// RULE8: One lamp per output channel; lamp index i belongs to output terminal i+1.
// RULE9: Flashing comes from a free-running clock divider at 50% duty; red beats green.
package lamp_pkg;

   // ==========================================================
   // Sizes
   localparam int NUM_CHANNELS = 8;
   localparam int MV_WIDTH = 16;
   localparam int FLASH_CNT_WIDTH = 24;

   // ==========================================================
   // Timing
   localparam int CLK_FREQ_HZ = 20_000_000;
   localparam int MS_PER_S = 1000;
   localparam int FAST_FLASH_PERIOD_MS = 1000;
   localparam int SLOW_FLASH_PERIOD_MS = 2000;
   // Half of the fast period; the slow flash is derived by halving the fast one
   localparam int FAST_HALF_CYCLES = CLK_FREQ_HZ / MS_PER_S * FAST_FLASH_PERIOD_MS / 2;

   // ==========================================================
   // Register map
   localparam int ADDR_WIDTH = 12;
   localparam logic [ADDR_WIDTH-1:0] ADDR_STATUS = 12'h000;
   localparam logic [ADDR_WIDTH-1:0] ADDR_MODE = 12'h004;
   localparam int STATUS_STATE_LSB = 0;
   localparam int STATUS_GREEN_BIT = 3;
   localparam int STATUS_RED_BIT = 4;
   localparam int STATUS_LAMPS_LSB = 8;
   localparam logic [NUM_CHANNELS-1:0] MODE_RESET = 8'h00;

   // ==========================================================
   // Types
   typedef enum logic {
      MODE_PULSE = 1'b0,
      MODE_LINEAR = 1'b1
   } out_mode_t;

   typedef enum logic [2:0] {
      ST_DARK = 3'b000,
      ST_GREEN_ON = 3'b001,
      ST_GREEN_FLASH = 3'b010,
      ST_RED_ON = 3'b011,
      ST_RED_FLASH = 3'b100
   } lamp_state_t;

   typedef struct packed {
      logic powerOk;
      logic restartHalt;
      logic initializing;
      logic restarting;
      logic downloading;
      logic ioReady;
      logic ioCheck;
      logic fatalErr;
      logic busErr;
   } unit_flags_t;

   typedef struct packed {
      logic outOn;
      logic signed [MV_WIDTH-1:0] mv;
   } chan_in_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_WIDTH-1:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } apb_rsp_t;

endpackage

// [flash_divider.sv]
`timescale 1ns/1ps
module flash_divider import lamp_pkg::*; #(
   parameter int HALF_CYCLES = FAST_HALF_CYCLES
) (
   // Clock, reset and enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Flash phases
   output logic fastPhase,
   output logic slowPhase
);
   localparam logic [FLASH_CNT_WIDTH-1:0] LAST = FLASH_CNT_WIDTH'(HALF_CYCLES - 1);

   logic [FLASH_CNT_WIDTH-1:0] cnt;
   logic [FLASH_CNT_WIDTH-1:0] next_cnt;
   logic next_fastPhase;
   logic next_slowPhase;

   // ==========================================================
   // Free-running divider: equal halves give an exact 50% duty
   always_comb begin
      next_cnt = cnt;
      next_fastPhase = fastPhase;
      next_slowPhase = slowPhase;
      if (ce) begin
         if (cnt == LAST) begin // see RULE9
            next_cnt = '0;
            next_fastPhase = ~fastPhase;
            // Slow phase toggles once per full fast period, so it stays aligned
            if (fastPhase) begin
               next_slowPhase = ~slowPhase;
            end
         end else begin
            next_cnt = cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
         fastPhase <= 1'b0;
         slowPhase <= 1'b0;
      end else begin
         cnt <= next_cnt;
         fastPhase <= next_fastPhase;
         slowPhase <= next_slowPhase;
      end
   end

   // ==========================================================
   // Checks
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Sampled reset keeps the edge that releases reset, where the flops still clear, out of it
   property p_phase_at_wrap;
      rst_n && $changed(fastPhase) |-> $past(cnt) == LAST && $past(ce);
   endproperty
   a_phase_at_wrap: assert property (p_phase_at_wrap) // see RULE9
      else $error("fast phase moved away from divider wrap");

endmodule

// [tb_status_lamp_driver.sv]
`timescale 1ns/1ps
module tb_status_lamp_driver import lamp_pkg::*;;
   // ==========================================================
   // Stimulus and observation
   localparam int HALF = 4;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   apb_req_t apbReq = '0;
   apb_rsp_t apbRsp;
   unit_flags_t unitFlags = '0;
   chan_in_t chanIn [NUM_CHANNELS];
   logic lampGreen;
   logic lampRed;
   logic [NUM_CHANNELS-1:0] outLamp;
   int errCount = 0;
   int nChecks = 0;
   logic [31:0] rd;
   logic err;

   // 20 MHz system clock
   always #25 clk = ~clk;

   status_lamp_driver #(.FLASH_HALF_CYCLES(HALF)) u_dut (
      .clk(clk), .rst_n(rst_n), .ce(ce), .apbReq(apbReq), .apbRsp(apbRsp),
      .unitFlags(unitFlags), .chanIn(chanIn), .lampGreen(lampGreen),
      .lampRed(lampRed), .outLamp(outLamp));

   // ==========================================================
   // Shared tasks
   // Returns in the edge's own time step: outputs read here still show what that edge sampled
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      nChecks++;
      if (seen !== exp) begin
         errCount++;
         $display("FAIL at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", nChecks, errCount);
      if (errCount == 0 && nChecks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // One APB transfer; the wait for pready is bounded
   task automatic apb(input logic wr, input logic [ADDR_WIDTH-1:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      tick(1);
      apbReq.penable <= 1'b1;
      do begin
         tick(1);
         n++;
      end while (apbRsp.pready !== 1'b1 && n < 20);
      if (apbRsp.pready !== 1'b1) begin
         errCount++;
         $display("FAIL at %0t: bus wait ran out", $time);
         conclude();
      end
      rd = apbRsp.prdata;
      err = apbRsp.pslverr;
      apbReq <= '0;
      tick(1);
   endtask

   // ==========================================================
   // Scenarios
   // Ten flag mixes, then 32 samples to measure duty and toggle rate
   task automatic test_status();
      logic [8:0] fl [10] = '{9'h0ff, 9'h1ff, 9'h1c1, 9'h1c8, 9'h140, 9'h128, 9'h110,
                              9'h108, 9'h104, 9'h100};
      logic [2:0] st [10] = '{3'h0, 3'h3, 3'h4, 3'h0, 3'h2, 3'h2, 3'h2, 3'h1, 3'h1, 3'h0};
      int g;
      int r;
      int chg;
      logic pg;
      logic pr;
      for (int i = 0; i < 10; i++) begin
         unitFlags <= fl[i];
         tick(2);
         apb(1'b0, ADDR_STATUS, 32'h0);
         check({29'h0, rd[2:0]}, {29'h0, st[i]}, "state");
         g = 0;
         r = 0;
         chg = 0;
         for (int k = 0; k < 32; k++) begin
            pg = lampGreen;
            pr = lampRed;
            tick(1);
            g += (lampGreen === 1'b1);
            r += (lampRed === 1'b1);
            chg += (lampGreen !== pg) + (lampRed !== pr);
         end
         check(g, st[i] == 3'h1 ? 32 : st[i] == 3'h2 ? 16 : 0, "green");
         check(r, st[i] == 3'h3 ? 32 : st[i] == 3'h4 ? 16 : 0, "red");
         check(chg, st[i] == 3'h2 ? 4 : st[i] == 3'h4 ? 8 : 0, "toggles");
      end
      $display("test status done");
   endtask

   // Pulsed and linear channels, including the zero and negative boundaries
   task automatic test_channels();
      logic [15:0] mv [8] = '{16'h8000, 16'hffff, 16'h0000, 16'h0001, 16'h0000, 16'h7fff,
                              16'h0000, 16'h7fff};
      logic [7:0] on = 8'h57;
      for (int i = 0; i < 8; i++) begin
         chanIn[i] <= '{outOn: ~on[i], mv: 16'h0001};
      end
      tick(2);
      check(outLamp, 8'ha8, "pulse lamps");
      apb(1'b1, ADDR_MODE, 32'hffff_ff0f);
      apb(1'b0, ADDR_MODE, 32'h0);
      check(rd, 32'h0000_000f, "mode readback");
      for (int i = 0; i < 8; i++) begin
         chanIn[i] <= '{outOn: on[i], mv: mv[i]};
      end
      tick(2);
      check(outLamp, 8'h58, "mixed lamps");
      apb(1'b0, ADDR_STATUS, 32'h0);
      check(rd[15:8], 8'h58, "status lamps");
      chanIn[3].mv <= 16'h0000;
      tick(2);
      check(outLamp, 8'h50, "zero mv");
      $display("test channels done");
   endtask

   // Unmapped places are refused; status ignores writes
   task automatic test_bus();
      logic [31:0] prior;
      apb(1'b0, 12'h008, 32'h0);
      check(err, 1'b1, "unmapped read error");
      check(rd, 32'h0, "unmapped read data");
      apb(1'b1, 12'h008, 32'h0);
      check(err, 1'b1, "unmapped write");
      apb(1'b0, ADDR_MODE, 32'h0);
      check(rd, 32'h0000_000f, "mode kept");
      apb(1'b0, ADDR_STATUS, 32'h0);
      prior = rd;
      apb(1'b1, ADDR_STATUS, 32'hffff_ffff);
      check(err, 1'b0, "status write");
      apb(1'b0, ADDR_STATUS, 32'h0);
      check(rd, prior, "status kept");
      $display("test bus done");
   endtask

   // Enable low freezes lamps and flashing and holds the bus off; inputs move meanwhile
   task automatic test_freeze();
      logic hold;
      unitFlags <= 9'h101;
      tick(2);
      ce <= 1'b0;
      unitFlags <= 9'h108;
      chanIn[4].outOn <= 1'b0;
      tick(1);
      hold = lampRed;
      for (int k = 0; k < 12; k++) begin
         tick(1);
         check({apbRsp.pready, lampGreen, lampRed, outLamp}, {2'h0, hold, 8'h50}, "frozen");
      end
      ce <= 1'b1;
      tick(2);
      check({lampGreen, lampRed, outLamp}, 10'h240, "thawed");
      $display("test freeze done");
   endtask

   // Reset in mid-run clears lamps and mode
   task automatic test_reset();
      rst_n <= 1'b0;
      tick(1);
      check({lampGreen, lampRed, outLamp}, 10'h0, "lamps in reset");
      rst_n <= 1'b1;
      tick(1);
      apb(1'b0, ADDR_MODE, 32'h0);
      check(rd, {24'h0, MODE_RESET}, "mode reset");
      check({lampGreen, lampRed, outLamp}, 10'h247, "lamps after reset");
      $display("test reset done");
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
         chanIn[i] = '0;
      end
      tick(5);
      check({lampGreen, lampRed, outLamp}, 10'h0, "lamps at start");
      rst_n <= 1'b1;
      tick(1);
      apb(1'b0, ADDR_MODE, 32'h0);
      check(rd, {24'h0, MODE_RESET}, "mode at start");
      test_status();
      test_channels();
      test_bus();
      test_freeze();
      test_reset();
      conclude();
   end
endmodule
